// File: rtl/srd_pkg.sv
// opcodes, field codes, clock counts and types for the stack/rotate/string decoder
package srd_pkg;

   // ==========================================================
   // opcode bytes
   localparam logic [7:0] OP_LOCK        = 8'hF0;
   localparam logic [7:0] OP_REP         = 8'hF3;
   localparam logic [7:0] OP_ESC         = 8'h0F;
   localparam logic [7:0] OP_PULL_RM     = 8'h8F;
   localparam logic [7:0] OP_GRP_FF      = 8'hFF;
   localparam logic [7:0] OP_PULL_ALL    = 8'h61;
   localparam logic [7:0] OP_PULL_FLAGS  = 8'h9D;
   localparam logic [7:0] OP_STORE_ALL   = 8'h60;
   localparam logic [7:0] OP_STORE_FLAGS = 8'h9C;
   localparam logic [7:0] OP_PULL_ES     = 8'h07;
   localparam logic [7:0] OP_PULL_SS     = 8'h17;
   localparam logic [7:0] OP_PULL_DS     = 8'h1F;
   localparam logic [7:0] OP_STORE_ES    = 8'h06;
   localparam logic [7:0] OP_STORE_CS    = 8'h0E;
   localparam logic [7:0] OP_STORE_SS    = 8'h16;
   localparam logic [7:0] OP_STORE_DS    = 8'h1E;
   localparam logic [4:0] OP_PULL_REG_HI  = 5'h0B;  // 58..5F
   localparam logic [4:0] OP_STORE_REG_HI = 5'h0A;  // 50..57
   localparam logic [5:0] OP_ROT_D_HI    = 6'h34;   // D0..D3
   localparam logic [6:0] OP_ROT_IMM_HI  = 7'h60;   // C0..C1
   localparam logic [6:0] OP_IN_STR_HI   = 7'h36;   // 6C..6D
   localparam logic [6:0] OP_OUT_STR_HI  = 7'h37;   // 6E..6F
   localparam logic [6:0] OP_LOAD_STR_HI = 7'h56;   // AC..AD
   localparam logic [6:0] OP_MOVE_STR_HI = 7'h52;   // A4..A5
   // second bytes after the escape
   localparam logic [7:0] OP2_MSR_RD     = 8'h32;
   localparam logic [7:0] OP2_TSC_RD     = 8'h31;
   localparam logic [7:0] OP2_PULL_FS    = 8'hA1;
   localparam logic [7:0] OP2_PULL_GS    = 8'hA9;
   localparam logic [7:0] OP2_STORE_FS   = 8'hA0;
   localparam logic [7:0] OP2_STORE_GS   = 8'hA8;

   // ==========================================================
   // modrm fields
   localparam logic [1:0] MOD_REG        = 2'h3;
   localparam logic [2:0] RF_PULL        = 3'h0;
   localparam logic [2:0] RF_STORE       = 3'h6;
   localparam logic [2:0] RF_RCL         = 3'h2;
   localparam logic [2:0] RF_RCR         = 3'h3;
   localparam int         MODRM_REG_LSB  = 3;
   localparam int         MODRM_MOD_LSB  = 6;
   localparam int         ROT_CNT_BIT    = 1;   // D2/D3 carry the count-register form

   // ==========================================================
   // cache-hit clock counts
   localparam logic [7:0] CK_ONE         = 8'h01;
   localparam logic [7:0] CK_PULL_MEM    = 8'h04;
   localparam logic [7:0] CK_SEG_PROT    = 8'h06;
   localparam logic [7:0] CK_PULL_ALL    = 8'h09;
   localparam logic [7:0] CK_PULL_FLAGS  = 8'h08;
   localparam logic [7:0] CK_STORE_MEM   = 8'h03;
   localparam logic [7:0] CK_STORE_ALL   = 8'h0B;
   localparam logic [7:0] CK_STORE_FLAGS = 8'h02;
   localparam logic [7:0] CK_RCL_ONE     = 8'h03;
   localparam logic [7:0] CK_RCR_ONE     = 8'h04;
   localparam logic [7:0] CK_ROT_MULTI   = 8'h08;
   localparam logic [7:0] CK_IN_BASE     = 8'h11;  // 17
   localparam logic [7:0] CK_IN_SLOW     = 8'h20;  // 32
   localparam logic [7:0] CK_OUT_BASE    = 8'h18;  // 24
   localparam logic [7:0] CK_OUT_SLOW    = 8'h27;  // 39
   localparam logic [7:0] CK_LOAD_BASE   = 8'h09;
   localparam logic [7:0] CK_MOVE_BASE   = 8'h0C;  // 12
   localparam int         SH_PORT_STR    = 2;      // 4 per iteration
   localparam int         SH_MEM_STR     = 1;      // 2 per iteration

   // ==========================================================
   // types
   typedef enum logic [4:0] {
      CL_NONE, CL_UNSUP, CL_PULL_RM, CL_PULL_REG, CL_PULL_SEG, CL_PULL_ALL,
      CL_PULL_FLAGS, CL_STORE_RM, CL_STORE_REG, CL_STORE_SEG, CL_STORE_ALL,
      CL_STORE_FLAGS, CL_RCL, CL_RCR, CL_MSR_RD, CL_TSC_RD, CL_REP_IN,
      CL_REP_LOAD, CL_REP_MOVE, CL_REP_OUT
   } srd_class_e;

   typedef enum logic [1:0] {FX_NONE = 2'h0, FX_CF_OF = 2'h1, FX_ALL = 2'h2} srd_flags_e;

   typedef enum logic [4:0] {
      ST_OPC   = 5'b00001,
      ST_ESC   = 5'b00010,
      ST_MODRM = 5'b00100,
      ST_IMM   = 5'b01000,
      ST_EXEC  = 5'b10000
   } srd_state_e;

endpackage

// File: rtl/srd_cycle_counter.sv
// down counter that times one instruction's clocks
module srd_cycle_counter #(
   parameter int W = 20
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic              busy,
   output logic              last
);
   logic [W-1:0] count_r;

   // ==========================================================
   // count down to zero after a load
   always_ff @(posedge clk)
   begin
      if (!resetn)
         count_r <= '0;
      else if (load)
         count_r <= load_val;
      else if (count_r != '0)
         count_r <= count_r - W'(1);
   end

   assign busy = (count_r != '0);
   assign last = (count_r == W'(1));  // final busy cycle
endmodule

// File: rtl/srd_decode.sv
// decode and timing of stack, lock, rotate-through-carry, model/timestamp read and repeated string
// How it works
// RULE1: 8F reg 000 pulls; 1 or 4 clocks
// RULE2: segment pull 1 clock real, 6 protected
// RULE3: 61 pulls all registers, 9 clocks, flags kept
// RULE4: 9D loads all flags in 8 clocks
// RULE5: F0 locks bus for next instruction
// RULE6: FF reg 110 stores; 1 or 3 clocks
// RULE7: segment store takes one clock
// RULE8: 60 stores all registers, 11 clocks, flags kept
// RULE9: 9C stores flags in 2 clocks
// RULE10: left carry rotate 3 or 8 clocks
// RULE11: right carry rotate 4 or 8 clocks
// RULE12: 0F 32 reads model register, flags kept
// RULE13: 0F 31 reads timestamp, flags kept
// RULE14: repeated port input 17+4n or 32+4n
// RULE15: repeated load string 9+2n clocks
// RULE16: repeated move string 12+2n clocks
// RULE17: repeated port output 24+4n or 39+4n
// RULE18: counts assume cache hits; misses stall more
module srd_decode
   import srd_pkg::*;
#(
   parameter int         CNT_W      = 16,
   parameter logic [7:0] MSR_CLOCKS = 8'h01,
   parameter logic [7:0] TSC_CLOCKS = 8'h01
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic                byte_valid,
   input  wire logic [7:0]          byte_data,
   output logic                     byte_ready,
   input  wire logic                prot_mode,
   input  wire logic                io_check_slow,
   input  wire logic [CNT_W-1:0]    rep_count,
   output logic                     dec_valid,
   output srd_class_e               dec_class,
   output logic [CNT_W+3:0]         dec_clocks,
   output srd_flags_e               dec_flags,
   output logic                     dec_mem_operand,
   output logic                     of_undef,
   output logic                     lock_out,
   output logic                     busy,
   output logic                     done
);
   localparam int CLK_W = CNT_W + 4;

   srd_state_e         state_r;
   srd_state_e         state_nxt;
   logic [7:0]         opc_r;
   logic               lock_pend_r;
   logic               rep_pend_r;
   logic               take;
   logic               issue;
   logic               hold;
   srd_class_e         cls;
   logic [CLK_W-1:0]   clk_cnt;
   srd_flags_e         fx;
   logic               mem;
   logic               ofu;
   logic [CLK_W-1:0]   n_ext;
   logic [1:0]         mrm_mod;
   logic [2:0]         mrm_reg;
   logic               cnt_busy;
   logic               cnt_last;
   logic [7:0]         lock_len_r;

   assign take    = byte_valid && byte_ready;
   assign n_ext   = {{4{1'b0}}, rep_count};
   assign mrm_mod = byte_data[MODRM_MOD_LSB +: 2];
   assign mrm_reg = byte_data[MODRM_REG_LSB +: 3];

   // ==========================================================
   // byte decode: picks next state and the finished instruction
   always_comb
   begin
      state_nxt = state_r;
      issue     = 1'b0;
      hold      = 1'b0;
      cls       = CL_UNSUP;
      clk_cnt   = CLK_W'(CK_ONE);
      fx        = FX_NONE;
      mem       = 1'b0;
      ofu       = 1'b0;
      unique case (state_r)
         ST_OPC:
            if (take)
            begin
               issue = 1'b1;
               if (byte_data == OP_LOCK || byte_data == OP_REP)
                  issue = 1'b0;             // prefix, stay here
               else if (byte_data == OP_ESC)
               begin
                  issue     = 1'b0;
                  state_nxt = ST_ESC;
               end
               else if (byte_data == OP_PULL_RM || byte_data == OP_GRP_FF
                        || byte_data[7:2] == OP_ROT_D_HI || byte_data[7:1] == OP_ROT_IMM_HI)
               begin
                  issue     = 1'b0;
                  state_nxt = ST_MODRM;
               end
               // RULE3: pull all registers
               else if (byte_data == OP_PULL_ALL)
               begin
                  cls     = CL_PULL_ALL;
                  clk_cnt = CLK_W'(CK_PULL_ALL);
               end
               // RULE4: pull flag word
               else if (byte_data == OP_PULL_FLAGS)
               begin
                  cls     = CL_PULL_FLAGS;
                  clk_cnt = CLK_W'(CK_PULL_FLAGS);
                  fx      = FX_ALL;
               end
               // RULE8: store all registers
               else if (byte_data == OP_STORE_ALL)
               begin
                  cls     = CL_STORE_ALL;
                  clk_cnt = CLK_W'(CK_STORE_ALL);
               end
               // RULE9: store flag word
               else if (byte_data == OP_STORE_FLAGS)
               begin
                  cls     = CL_STORE_FLAGS;
                  clk_cnt = CLK_W'(CK_STORE_FLAGS);
               end
               // RULE2: segment pull, descriptor load when protected
               else if (byte_data == OP_PULL_ES || byte_data == OP_PULL_SS
                        || byte_data == OP_PULL_DS)
               begin
                  cls     = CL_PULL_SEG;
                  clk_cnt = CLK_W'(prot_mode ? CK_SEG_PROT : CK_ONE);
               end
               // RULE7: segment store
               else if (byte_data == OP_STORE_ES || byte_data == OP_STORE_CS
                        || byte_data == OP_STORE_SS || byte_data == OP_STORE_DS)
                  cls = CL_STORE_SEG;
               else if (byte_data[7:3] == OP_PULL_REG_HI)
                  cls = CL_PULL_REG;
               else if (byte_data[7:3] == OP_STORE_REG_HI)
                  cls = CL_STORE_REG;
               // RULE14: repeated port input
               else if (rep_pend_r && byte_data[7:1] == OP_IN_STR_HI)
               begin
                  cls     = CL_REP_IN;
                  clk_cnt = CLK_W'(prot_mode && io_check_slow ? CK_IN_SLOW : CK_IN_BASE)
                            + (n_ext << SH_PORT_STR);
               end
               // RULE17: repeated port output
               else if (rep_pend_r && byte_data[7:1] == OP_OUT_STR_HI)
               begin
                  cls     = CL_REP_OUT;
                  clk_cnt = CLK_W'(prot_mode && io_check_slow ? CK_OUT_SLOW : CK_OUT_BASE)
                            + (n_ext << SH_PORT_STR);
               end
               // RULE15: repeated load string
               else if (rep_pend_r && byte_data[7:1] == OP_LOAD_STR_HI)
               begin
                  cls     = CL_REP_LOAD;
                  clk_cnt = CLK_W'(CK_LOAD_BASE) + (n_ext << SH_MEM_STR);
               end
               // RULE16: repeated move string
               else if (rep_pend_r && byte_data[7:1] == OP_MOVE_STR_HI)
               begin
                  cls     = CL_REP_MOVE;
                  clk_cnt = CLK_W'(CK_MOVE_BASE) + (n_ext << SH_MEM_STR);
               end
            end
         ST_ESC:
            if (take)
            begin
               issue = 1'b1;
               // RULE12: model register read
               if (byte_data == OP2_MSR_RD)
               begin
                  cls     = CL_MSR_RD;
                  clk_cnt = CLK_W'(MSR_CLOCKS);
               end
               // RULE13: timestamp read
               else if (byte_data == OP2_TSC_RD)
               begin
                  cls     = CL_TSC_RD;
                  clk_cnt = CLK_W'(TSC_CLOCKS);
               end
               else if (byte_data == OP2_PULL_FS || byte_data == OP2_PULL_GS)
               begin
                  cls     = CL_PULL_SEG;
                  clk_cnt = CLK_W'(prot_mode ? CK_SEG_PROT : CK_ONE);
               end
               else if (byte_data == OP2_STORE_FS || byte_data == OP2_STORE_GS)
                  cls = CL_STORE_SEG;
            end
         ST_MODRM:
            if (take)
            begin
               issue = 1'b1;
               mem   = (mrm_mod != MOD_REG);
               // RULE1: pull to register or memory
               if (opc_r == OP_PULL_RM && mrm_reg == RF_PULL)
               begin
                  cls     = CL_PULL_RM;
                  clk_cnt = CLK_W'(mem ? CK_PULL_MEM : CK_ONE);
               end
               // RULE6: store register or memory
               else if (opc_r == OP_GRP_FF && mrm_reg == RF_STORE)
               begin
                  cls     = CL_STORE_RM;
                  clk_cnt = CLK_W'(mem ? CK_STORE_MEM : CK_ONE);
               end
               // RULE10: left rotate through carry
               // RULE11: right rotate through carry
               else if ((opc_r[7:2] == OP_ROT_D_HI || opc_r[7:1] == OP_ROT_IMM_HI)
                        && (mrm_reg == RF_RCL || mrm_reg == RF_RCR))
               begin
                  cls = (mrm_reg == RF_RCL) ? CL_RCL : CL_RCR;
                  fx  = FX_CF_OF;
                  ofu = (opc_r[7:2] != OP_ROT_D_HI) || opc_r[ROT_CNT_BIT];
                  if (ofu)
                     clk_cnt = CLK_W'(CK_ROT_MULTI);
                  else
                     clk_cnt = CLK_W'(mrm_reg == RF_RCL ? CK_RCL_ONE : CK_RCR_ONE);
                  if (opc_r[7:1] == OP_ROT_IMM_HI)
                  begin
                     issue = 1'b0;          // count byte still to come
                     hold  = 1'b1;
                  end
               end
               if (!issue)
                  state_nxt = hold ? ST_IMM : ST_OPC;
            end
         ST_IMM:
            issue = take;
         ST_EXEC:
            if (cnt_last)
               state_nxt = ST_OPC;
      endcase
      if (issue)
         state_nxt = ST_EXEC;
   end

   // ==========================================================
   // state and the first opcode byte
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_r <= ST_OPC;
         opc_r   <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (take && state_r == ST_OPC)
            opc_r <= byte_data;
      end
   end

   // ==========================================================
   // decoded result, kept until the next instruction; the immediate
   // form keeps what the modrm byte produced
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         dec_valid       <= 1'b0;
         dec_class       <= CL_NONE;
         dec_clocks      <= '0;
         dec_flags       <= FX_NONE;
         dec_mem_operand <= 1'b0;
         of_undef        <= 1'b0;
      end
      else
      begin
         dec_valid <= issue;
         if ((issue && state_r != ST_IMM) || hold)
         begin
            dec_class       <= cls;
            dec_clocks      <= clk_cnt;
            dec_flags       <= fx;
            dec_mem_operand <= mem;
            of_undef        <= ofu;
         end
      end
   end

   // ==========================================================
   // prefixes; a prefix arriving with nothing after it waits
   // RULE5: lock held from issue to completion
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         lock_pend_r <= 1'b0;
         rep_pend_r  <= 1'b0;
         lock_out    <= 1'b0;
      end
      else
      begin
         if (issue)
         begin
            lock_out    <= lock_pend_r;
            lock_pend_r <= 1'b0;
            rep_pend_r  <= 1'b0;
         end
         else
         begin
            if (take && state_r == ST_OPC && byte_data == OP_LOCK)
               lock_pend_r <= 1'b1;
            if (take && state_r == ST_OPC && byte_data == OP_REP)
               rep_pend_r <= 1'b1;
            if (cnt_last)
               lock_out <= 1'b0;
         end
      end
   end

   // ==========================================================
   // execution timer; miss stalls are added outside this block
   // RULE18: cache-hit counts only
   srd_cycle_counter #(.W(CLK_W)) u_timer (
      .clk      (clk),
      .resetn   (resetn),
      .load     (dec_valid),
      .load_val (dec_clocks),
      .busy     (cnt_busy),
      .last     (cnt_last)
   );

   assign busy       = cnt_busy;
   assign done       = cnt_last;
   assign byte_ready = (state_r != ST_EXEC);

   // ==========================================================
   // checks
   // length of the current lock run, saturating so long strings cannot wrap it
   always_ff @(posedge clk)
   begin
      if (!resetn)
         lock_len_r <= 8'h00;
      else if (!lock_out)
         lock_len_r <= 8'h00;
      else if (lock_len_r != 8'hFF)
         lock_len_r <= lock_len_r + 8'h01;
   end

   sequence s_lock_then_store_all;
      take && state_r == ST_OPC && byte_data == OP_LOCK
      ##1 take && state_r == ST_OPC && byte_data == OP_STORE_ALL;
   endsequence

   a_pull_rm_time: assert property (@(posedge clk) disable iff (!resetn) // RULE1
      dec_valid && dec_class == CL_PULL_RM |-> dec_clocks == (dec_mem_operand ? 4 : 1))
      else $error("pull r/m clock count wrong");
   a_seg_pull_time: assert property (@(posedge clk) disable iff (!resetn) // RULE2
      dec_valid && dec_class == CL_PULL_SEG |-> dec_clocks == ($past(prot_mode) ? 6 : 1))
      else $error("segment pull clock count wrong");
   a_pull_all_keep: assert property (@(posedge clk) disable iff (!resetn) // RULE3
      dec_valid && dec_class == CL_PULL_ALL |-> dec_clocks == 9 && dec_flags == FX_NONE)
      else $error("pull all decode wrong");
   a_pull_flags_all: assert property (@(posedge clk) disable iff (!resetn) // RULE4
      dec_valid && dec_class == CL_PULL_FLAGS |=> busy [*8] ##1 !busy)
      else $error("flag pull did not run 8 clocks");
   a_lock_follow: assert property (@(posedge clk) disable iff (!resetn) // RULE5
      s_lock_then_store_all |=> lock_out && dec_valid ##12 !lock_out && lock_len_r == 8'h0C)
      else $error("lock not held over locked instruction");
   a_store_rm_time: assert property (@(posedge clk) disable iff (!resetn) // RULE6
      dec_valid && dec_class == CL_STORE_RM |-> dec_clocks == (dec_mem_operand ? 3 : 1))
      else $error("store r/m clock count wrong");
   a_store_seg_one: assert property (@(posedge clk) disable iff (!resetn) // RULE7
      dec_valid && dec_class == CL_STORE_SEG |=> done)
      else $error("segment store not one clock");
   a_store_all_time: assert property (@(posedge clk) disable iff (!resetn) // RULE8
      dec_valid && dec_class == CL_STORE_ALL |-> dec_clocks == 11 && dec_flags == FX_NONE)
      else $error("store all decode wrong");
   a_store_flags_two: assert property (@(posedge clk) disable iff (!resetn) // RULE9
      dec_valid && dec_class == CL_STORE_FLAGS |=> !done ##1 done)
      else $error("flag store not two clocks");
   a_rot_left_flags: assert property (@(posedge clk) disable iff (!resetn) // RULE10
      dec_valid && dec_class == CL_RCL
      |-> dec_flags == FX_CF_OF && dec_clocks == (of_undef ? 8 : 3))
      else $error("left rotate decode wrong");
   a_rot_right_flags: assert property (@(posedge clk) disable iff (!resetn) // RULE11
      dec_valid && dec_class == CL_RCR
      |-> dec_flags == FX_CF_OF && dec_clocks == (of_undef ? 8 : 4))
      else $error("right rotate decode wrong");
   a_esc_reads_keep: assert property (@(posedge clk) disable iff (!resetn) // RULE12
      take && state_r == ST_ESC && (byte_data == OP2_MSR_RD || byte_data == OP2_TSC_RD)
      |=> dec_valid && dec_flags == FX_NONE) // RULE13
      else $error("escape read decode wrong");
   a_rep_move_time: assert property (@(posedge clk) disable iff (!resetn) // RULE16
      dec_valid && dec_class == CL_REP_MOVE |-> dec_clocks == 12 + 2 * $past(rep_count))
      else $error("repeated move clock count wrong");
   a_rep_out_time: assert property (@(posedge clk) disable iff (!resetn) // RULE17
      dec_valid && dec_class == CL_REP_OUT |-> dec_clocks == ($past(prot_mode && io_check_slow)
         ? 39 : 24) + 4 * $past(rep_count))
      else $error("repeated output clock count wrong");
endmodule

// File: bench/srd_decode_tb.sv
// self-checking bench for the stack, lock, rotate and string decoder
module srd_decode_tb
   import srd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // design signals and bench counters
   logic         clk;
   logic         resetn;
   logic         byte_valid;
   logic [7:0]   byte_data;
   logic         byte_ready;
   logic         prot_mode;
   logic         io_check_slow;
   logic [15:0]  rep_count;
   logic         dec_valid;
   srd_class_e   dec_class;
   logic [19:0]  dec_clocks;
   srd_flags_e   dec_flags;
   logic         dec_mem_operand;
   logic         of_undef;
   logic         lock_out;
   logic         busy;
   logic         done;
   int           err_count;
   int           checks_done;
   int           cyc = 0;

   srd_decode #(.CNT_W(16)) DUT (.clk(clk), .resetn(resetn), .byte_valid(byte_valid),
      .byte_data(byte_data), .byte_ready(byte_ready), .prot_mode(prot_mode),
      .io_check_slow(io_check_slow), .rep_count(rep_count), .dec_valid(dec_valid),
      .dec_class(dec_class), .dec_clocks(dec_clocks), .dec_flags(dec_flags),
      .dec_mem_operand(dec_mem_operand), .of_undef(of_undef), .lock_out(lock_out),
      .busy(busy), .done(done));

   // ==========================================================
   // common tasks
   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
      end
   endtask

   // offer n bytes back to back, then judge decode, busy length and lock release
   task automatic run(input logic [23:0] b, input int n, input srd_class_e cls,
                      input int ck, input srd_flags_e fx, input logic lk);
      int i;
      int cnt;
      for (i = 0; i < n; i++)
      begin
         byte_data = b[23-8*i -: 8];
         byte_valid = 1'b1;
         @(posedge clk);
         #10;
      end
      byte_valid = 1'b0;
      cnt = 0;
      while (dec_valid !== 1'b1 && cnt < 4)
      begin
         @(posedge clk);
         #10;
         cnt++;
      end
      chk({dec_valid, dec_class, dec_flags, lock_out}, {1'b1, cls, fx, lk}, "decode");
      chk(dec_clocks, ck, "clock count");
      cnt = 0;
      i = 0;
      // bounded wait: a lost done must not hang the run
      while (done !== 1'b1 && i < 300)
      begin
         @(posedge clk);
         #10;
         i++;
         cnt = cnt + (busy === 1'b1);
      end
      chk(cnt, ck, "busy length");
      chk({done, busy}, 2'b11, "done on last busy");
      @(posedge clk);
      #10;
      chk({lock_out, byte_ready}, 2'b01, "lock drop and ready");
   endtask

   // ==========================================================
   // scenarios
   task automatic t_stack();
      run(24'h8FC000, 2, CL_PULL_RM, 1, FX_NONE, 0);
      run(24'h8F0000, 2, CL_PULL_RM, 4, FX_NONE, 0);
      chk(dec_mem_operand, 1, "memory operand");
      run(24'h8FC800, 2, CL_UNSUP, 1, FX_NONE, 0);
      run(24'hFFF000, 2, CL_STORE_RM, 1, FX_NONE, 0);
      run(24'hFF3000, 2, CL_STORE_RM, 3, FX_NONE, 0);
      run(24'h5B0000, 1, CL_PULL_REG, 1, FX_NONE, 0);
      run(24'h530000, 1, CL_STORE_REG, 1, FX_NONE, 0);
   endtask

   task automatic t_segment();
      int m;
      for (m = 0; m < 2; m++)
      begin
         prot_mode = m[0];
         run(24'h070000, 1, CL_PULL_SEG, m ? 6 : 1, FX_NONE, 0);
         run(24'h170000, 1, CL_PULL_SEG, m ? 6 : 1, FX_NONE, 0);
         run(24'h1F0000, 1, CL_PULL_SEG, m ? 6 : 1, FX_NONE, 0);
         run(24'h060000, 1, CL_STORE_SEG, 1, FX_NONE, 0);
         run(24'h0E0000, 1, CL_STORE_SEG, 1, FX_NONE, 0);
         run(24'h160000, 1, CL_STORE_SEG, 1, FX_NONE, 0);
         run(24'h1E0000, 1, CL_STORE_SEG, 1, FX_NONE, 0);
         run(24'h0FA100, 2, CL_PULL_SEG, m ? 6 : 1, FX_NONE, 0);
         run(24'h0FA800, 2, CL_STORE_SEG, 1, FX_NONE, 0);
      end
   endtask

   // whole-set and flag-word forms, lock only on the next instruction
   task automatic t_whole_and_lock();
      run(24'h610000, 1, CL_PULL_ALL, 9, FX_NONE, 0);
      run(24'h9D0000, 1, CL_PULL_FLAGS, 8, FX_ALL, 0);
      run(24'hF06000, 2, CL_STORE_ALL, 11, FX_NONE, 1);
      run(24'h9C0000, 1, CL_STORE_FLAGS, 2, FX_NONE, 0);
      run(24'hF0F09D, 3, CL_PULL_FLAGS, 8, FX_ALL, 1);
      run(24'h600000, 1, CL_STORE_ALL, 11, FX_NONE, 0);
   endtask

   task automatic t_rotate();
      run(24'hD0D000, 2, CL_RCL, 3, FX_CF_OF, 0);
      chk(of_undef, 0, "single rotate overflow");
      run(24'hD3D000, 2, CL_RCL, 8, FX_CF_OF, 0);
      chk(of_undef, 1, "multi rotate overflow");
      run(24'hC0D005, 3, CL_RCL, 8, FX_CF_OF, 0);
      run(24'hD1D800, 2, CL_RCR, 4, FX_CF_OF, 0);
      run(24'hD2D800, 2, CL_RCR, 8, FX_CF_OF, 0);
      run(24'hC1D802, 3, CL_RCR, 8, FX_CF_OF, 0);
      run(24'h0F3200, 2, CL_MSR_RD, 1, FX_NONE, 0);
      run(24'h0F3100, 2, CL_TSC_RD, 1, FX_NONE, 0);
   endtask

   // repeated string timing across modes and slow port checks
   task automatic t_rep();
      rep_count = 16'h0005;
      prot_mode = 1'b0;
      io_check_slow = 1'b1;
      run(24'hF36C00, 2, CL_REP_IN, 17 + 4 * 5, FX_NONE, 0);
      run(24'hF36F00, 2, CL_REP_OUT, 24 + 4 * 5, FX_NONE, 0);
      prot_mode = 1'b1;
      run(24'hF36D00, 2, CL_REP_IN, 32 + 4 * 5, FX_NONE, 0);
      run(24'hF36E00, 2, CL_REP_OUT, 39 + 4 * 5, FX_NONE, 0);
      io_check_slow = 1'b0;
      run(24'hF36C00, 2, CL_REP_IN, 17 + 4 * 5, FX_NONE, 0);
      run(24'hF36F00, 2, CL_REP_OUT, 24 + 4 * 5, FX_NONE, 0);
      rep_count = 16'h0000;
      run(24'hF3AC00, 2, CL_REP_LOAD, 9, FX_NONE, 0);
      run(24'hF3A500, 2, CL_REP_MOVE, 12, FX_NONE, 0);
      rep_count = 16'h0007;
      run(24'hF3AD00, 2, CL_REP_LOAD, 9 + 2 * 7, FX_NONE, 0);
      run(24'hF3A400, 2, CL_REP_MOVE, 12 + 2 * 7, FX_NONE, 0);
      run(24'hA40000, 1, CL_UNSUP, 1, FX_NONE, 0);
   endtask

   // ==========================================================
   // clock, watchdog and main sequence
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // roughly 640 cycles are needed; the ceiling leaves wide margin
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      resetn = 1'b0;
      byte_valid = 1'b0;
      byte_data = 8'h00;
      prot_mode = 1'b0;
      io_check_slow = 1'b0;
      rep_count = 16'h0000;
      err_count = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      #10;
      chk({byte_ready, lock_out, busy, dec_valid, dec_class}, {4'h8, CL_NONE}, "reset state");
      resetn = 1'b1;
      @(posedge clk);
      #10;
      t_stack();
      t_segment();
      t_whole_and_lock();
      t_rotate();
      t_rep();
      final_report();
   end
endmodule
